// ===== hdl/sad_pkg.sv
// Package of register map, field positions and constants for the shock detector
package sad_pkg;
	// Sample, counter and rate code widths
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned CNT_W    = 9;
	localparam int unsigned RATE_W   = 4;
	// Register addresses and register reset value
	localparam logic [7:0] ADDR_THRESH   = 8'h1D;
	localparam logic [7:0] ADDR_OFS_X    = 8'h1E;
	localparam logic [7:0] ADDR_OFS_Y    = 8'h1F;
	localparam logic [7:0] ADDR_OFS_Z    = 8'h20;
	localparam logic [7:0] ADDR_LIMIT    = 8'h21;
	localparam logic [7:0] ADDR_GAP      = 8'h22;
	localparam logic [7:0] ADDR_INTERVAL = 8'h23;
	localparam logic [7:0] ADDR_AXIS     = 8'h2A;
	localparam logic [7:0] ADDR_STATUS   = 8'h2B;
	localparam logic [7:0] ADDR_RATE     = 8'h2C;
	localparam logic [7:0] ADDR_POWER    = 8'h2D;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h2E;
	localparam logic [7:0] ADDR_ROUTE    = 8'h2F;
	localparam logic [7:0] ADDR_IRQ_SRC  = 8'h30;
	localparam logic [7:0] ADDR_FORMAT   = 8'h31;
	localparam logic [7:0] REG_RESET     = 8'h00;
	// Field positions
	localparam int unsigned BIT_SINGLE     = 6;
	localparam int unsigned BIT_DOUBLE     = 5;
	localparam int unsigned BIT_ACT        = 4;
	localparam int unsigned BIT_INACT      = 3;
	localparam int unsigned BIT_SUPPRESS   = 3;
	localparam int unsigned BIT_ASLEEP     = 3;
	localparam int unsigned BIT_LINK       = 5;
	localparam int unsigned BIT_AUTO_SLEEP = 4;
	localparam int unsigned BIT_LOW_POWER  = 4;
	localparam int unsigned BIT_INVERT     = 5;
	// Rate code used while asleep
	localparam logic [3:0] SLEEP_RATE = 4'h7;
	// Offset scaling: offset weight over sample weight, rounded
	localparam int unsigned OFS_MG_PER_LSB    = 1560;
	localparam int unsigned SAMPLE_MG_PER_LSB = 49;
	localparam int unsigned OFS_SCALE =
		(OFS_MG_PER_LSB + SAMPLE_MG_PER_LSB / 2) / SAMPLE_MG_PER_LSB;
	// Threshold compare shift of sample magnitude
	localparam int unsigned THRESH_SHIFT = 4;
	// Saturation limits of the corrected sample
	localparam logic [15:0] SAT_MAX = 16'h7FFF;
	localparam logic [15:0] SAT_MIN = 16'h8000;
	// Shock sequence states
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_FIRST  = 6'h02,
		ST_GAP    = 6'h04,
		ST_WIN    = 6'h08,
		ST_SECOND = 6'h10,
		ST_SETTLE = 6'h20
	} sad_state_type;
endpackage

// ===== hdl/sad_sample_if.sv
// Interface carrying samples between the core and the sample path
`timescale 1ns/1ps
`default_nettype none
interface sad_sample_if;
	logic             tick;
	logic [2:0][15:0] raw;
	logic [2:0][7:0]  ofs;
	logic [7:0]       thresh;
	logic [2:0]       axis_en;
	logic [2:0][15:0] data;
	logic [2:0]       above;
	logic             data_tick;
	modport path (input tick, raw, ofs, thresh, axis_en, output data, above, data_tick);
	modport core (output tick, raw, ofs, thresh, axis_en, input data, above, data_tick);
endinterface
`default_nettype wire

// ===== hdl/sad_sample_path.sv
// Offset correction and threshold compare of each sample
`timescale 1ns/1ps
`default_nettype none
module sad_sample_path (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  reset_n,
	// Sample stream
	sad_sample_if.path sif
);
	// Adds scaled offset with saturation
	function automatic logic [15:0] sat_add(input logic [15:0] s, input logic [7:0] o);
		logic [17:0] sum;
		sum = 18'(signed'(s)) + 18'(signed'(o)) * 18'(sad_pkg::OFS_SCALE);
		if (sum[17:15] == 3'h0 || sum[17:15] == 3'h7)
			sat_add = sum[15:0];
		else if (sum[17])
			sat_add = sad_pkg::SAT_MIN;
		else
			sat_add = sad_pkg::SAT_MAX;
	endfunction

	// Magnitude of a two's complement sample
	function automatic logic [15:0] magnitude(input logic [15:0] s);
		magnitude = s[15] ? 16'(-s) : s;
	endfunction

	logic [2:0][15:0] corr;
	logic [2:0]       exceed;
	logic [2:0][15:0] data_q;
	logic [2:0]       above_q;
	logic             tick_q;

	// Correction and compare per axis
	for (genvar i = 0; i < 3; i++)
	begin : g_axis
		assign corr[i]   = sat_add(sif.raw[i], sif.ofs[i]);
		assign exceed[i] = sif.axis_en[i] &&
			((magnitude(corr[i]) >> sad_pkg::THRESH_SHIFT) > 16'(sif.thresh));
	end

	// Capture corrected data every undecimated tick
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			data_q  <= '0;
			above_q <= '0;
			tick_q  <= 1'b0;
		end
		else
		begin
			tick_q <= sif.tick;
			if (sif.tick)
			begin
				data_q  <= corr;
				above_q <= exceed;
			end
		end
	end

	assign sif.data      = data_q;
	assign sif.above     = above_q;
	assign sif.data_tick = tick_q;

	a_offset_zero_pass: assert property (@(posedge clk) disable iff (!reset_n)
		(sif.tick && sif.ofs[0] == 8'h00) |=> (data_q[0] == $past(sif.raw[0])))
		else $error("zero offset altered x sample");
endmodule
`default_nettype wire

// ===== hdl/sad_shock_core.sv
// Shock, activity and sleep event logic with register file
`timescale 1ns/1ps
`default_nettype none
module sad_shock_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Raw undecimated samples
	input  wire logic        sample_tick,
	input  wire logic [15:0] raw_x,
	input  wire logic [15:0] raw_y,
	input  wire logic [15:0] raw_z,
	// Motion detector events
	input  wire logic        activity_hit,
	input  wire logic        inactivity_hit,
	// Corrected data
	output logic      [15:0] data_x,
	output logic      [15:0] data_y,
	output logic      [15:0] data_z,
	output logic             data_tick,
	// Interrupt pins and power state
	output logic             irq_pin_a,
	output logic             irq_pin_b,
	output logic             asleep,
	output logic      [3:0]  rate_code,
	output logic             low_power
);
	// Picks the first axis above threshold, x first, as {x,y,z}
	function automatic logic [2:0] first_axis(input logic [2:0] a);
		if (a[0])
			first_axis = 3'h4;
		else if (a[1])
			first_axis = 3'h2;
		else if (a[2])
			first_axis = 3'h1;
		else
			first_axis = 3'h0;
	endfunction

	// Configuration registers
	logic [7:0]      thresh_q;
	logic [2:0][7:0] ofs_q;
	logic [7:0]      limit_q;
	logic [7:0]      gap_q;
	logic [7:0]      interval_q;
	logic [7:0]      axis_q;
	logic [7:0]      rate_q;
	logic [7:0]      power_q;
	logic [7:0]      irq_en_q;
	logic [7:0]      route_q;
	logic [7:0]      format_q;
	// Event state
	logic [7:0]      flags_q;
	logic [7:0]      flags_d;
	logic [2:0]      shock_axis_q;
	logic [2:0]      cand_q;
	logic [2:0]      cand_d;
	logic            asleep_q;
	logic            asleep_d;
	logic            look_inact_q;
	logic            look_inact_d;
	logic            pend_q;
	logic            pend_d;
	logic [8:0]      cnt_q;
	logic [8:0]      cnt_d;
	logic [8:0]      cnt_inc;
	logic [7:0]      rdata_q;
	logic [7:0]      rd_mux;
	logic            pin_a_q;
	logic            pin_b_q;
	logic [3:0]      rate_code_q;
	sad_pkg::sad_state_type state_q;
	sad_pkg::sad_state_type state_d;
	sad_sample_if           sif ();

	// Decoded controls
	wire       any_above = |sif.above;
	wire       single_en = irq_en_q[sad_pkg::BIT_SINGLE];
	wire       double_en = irq_en_q[sad_pkg::BIT_DOUBLE];
	wire       dbl_ok    = double_en && (gap_q != 8'h00) && (interval_q != 8'h00);
	wire       suppress  = axis_q[sad_pkg::BIT_SUPPRESS];
	wire       link      = power_q[sad_pkg::BIT_LINK];
	wire       auto_slp  = power_q[sad_pkg::BIT_AUTO_SLEEP];
	wire       invert    = format_q[sad_pkg::BIT_INVERT];
	wire       src_read  = reg_rd && (reg_addr == sad_pkg::ADDR_IRQ_SRC);
	wire [7:0] status    = {4'h0, asleep_q, shock_axis_q};

	// Activity and inactivity acceptance, chained when linked
	wire act_ev   = activity_hit && irq_en_q[sad_pkg::BIT_ACT] &&
		(!link || !look_inact_q);
	wire inact_ev = inactivity_hit && irq_en_q[sad_pkg::BIT_INACT] &&
		(!link || look_inact_q);
	wire sleep_go = inact_ev && auto_slp && link && !flags_q[sad_pkg::BIT_ACT];
	wire wake     = act_ev && asleep_q;

	logic ev_single;
	logic ev_double;

	// Sample path hookup; sampling runs in every power mode
	assign sif.tick    = sample_tick;
	assign sif.raw     = {raw_z, raw_y, raw_x};
	assign sif.ofs     = ofs_q;
	assign sif.thresh  = thresh_q;
	assign sif.axis_en = {axis_q[0], axis_q[1], axis_q[2]};

	sad_sample_path u_path (
		.clk     (clk),
		.reset_n (reset_n),
		.sif     (sif.path)
	);

	// Register writes
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			thresh_q   <= sad_pkg::REG_RESET;
			ofs_q      <= '0;
			limit_q    <= sad_pkg::REG_RESET;
			gap_q      <= sad_pkg::REG_RESET;
			interval_q <= sad_pkg::REG_RESET;
			axis_q     <= sad_pkg::REG_RESET;
			rate_q     <= sad_pkg::REG_RESET;
			power_q    <= sad_pkg::REG_RESET;
			irq_en_q   <= sad_pkg::REG_RESET;
			route_q    <= sad_pkg::REG_RESET;
			format_q   <= sad_pkg::REG_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				sad_pkg::ADDR_THRESH:   thresh_q   <= reg_wdata;
				sad_pkg::ADDR_OFS_X:    ofs_q[0]   <= reg_wdata;
				sad_pkg::ADDR_OFS_Y:    ofs_q[1]   <= reg_wdata;
				sad_pkg::ADDR_OFS_Z:    ofs_q[2]   <= reg_wdata;
				sad_pkg::ADDR_LIMIT:    limit_q    <= reg_wdata;
				sad_pkg::ADDR_GAP:      gap_q      <= reg_wdata;
				sad_pkg::ADDR_INTERVAL: interval_q <= reg_wdata;
				sad_pkg::ADDR_AXIS:     axis_q     <= reg_wdata;
				sad_pkg::ADDR_RATE:     rate_q     <= reg_wdata;
				sad_pkg::ADDR_POWER:    power_q    <= reg_wdata;
				sad_pkg::ADDR_IRQ_EN:   irq_en_q   <= reg_wdata;
				sad_pkg::ADDR_ROUTE:    route_q    <= reg_wdata;
				sad_pkg::ADDR_FORMAT:   format_q   <= reg_wdata;
				default:                ;
			endcase
		end
	end

	// Read selection; unmapped addresses read zero
	always_comb
	begin
		case (reg_addr)
			sad_pkg::ADDR_THRESH:   rd_mux = thresh_q;
			sad_pkg::ADDR_OFS_X:    rd_mux = ofs_q[0];
			sad_pkg::ADDR_OFS_Y:    rd_mux = ofs_q[1];
			sad_pkg::ADDR_OFS_Z:    rd_mux = ofs_q[2];
			sad_pkg::ADDR_LIMIT:    rd_mux = limit_q;
			sad_pkg::ADDR_GAP:      rd_mux = gap_q;
			sad_pkg::ADDR_INTERVAL: rd_mux = interval_q;
			sad_pkg::ADDR_AXIS:     rd_mux = axis_q;
			sad_pkg::ADDR_STATUS:   rd_mux = status;
			sad_pkg::ADDR_RATE:     rd_mux = rate_q;
			sad_pkg::ADDR_POWER:    rd_mux = power_q;
			sad_pkg::ADDR_IRQ_EN:   rd_mux = irq_en_q;
			sad_pkg::ADDR_ROUTE:    rd_mux = route_q;
			sad_pkg::ADDR_IRQ_SRC:  rd_mux = flags_q;
			sad_pkg::ADDR_FORMAT:   rd_mux = format_q;
			default:                rd_mux = 8'h00;
		endcase
	end

	// Shock sequence, advanced once per corrected sample
	assign cnt_inc = cnt_q + 9'h001;
	always_comb
	begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		pend_d    = pend_q;
		cand_d    = cand_q;
		ev_single = 1'b0;
		ev_double = 1'b0;
		if (sif.data_tick)
		begin
			case (state_q)
				sad_pkg::ST_IDLE:
					if (any_above && (single_en || dbl_ok))
					begin
						state_d = sad_pkg::ST_FIRST;
						cnt_d   = 9'h001;
						cand_d  = first_axis(sif.above);
					end
				sad_pkg::ST_FIRST:
					if (any_above)
					begin
						cnt_d = cnt_inc;
						if (cnt_inc > 9'(limit_q))
							state_d = sad_pkg::ST_SETTLE;
					end
					else if (dbl_ok)
					begin
						state_d = sad_pkg::ST_GAP;
						cnt_d   = 9'h000;
						pend_d  = single_en;
					end
					else
					begin
						ev_single = single_en;
						state_d   = sad_pkg::ST_IDLE;
					end
				sad_pkg::ST_GAP:
					if (any_above && suppress)
					begin
						ev_single = pend_q;
						pend_d    = 1'b0;
						state_d   = sad_pkg::ST_SETTLE;
					end
					else
					begin
						cnt_d = cnt_inc;
						if (cnt_inc >= 9'(gap_q))
						begin
							cnt_d = 9'h000;
							if (any_above)
							begin
								ev_single = pend_q;
								pend_d    = 1'b0;
								state_d   = sad_pkg::ST_SETTLE;
							end
							else
								state_d = sad_pkg::ST_WIN;
						end
					end
				sad_pkg::ST_WIN:
					if (any_above)
					begin
						state_d = sad_pkg::ST_SECOND;
						cnt_d   = 9'h001;
					end
					else
					begin
						cnt_d = cnt_inc;
						if (cnt_inc >= 9'(interval_q))
						begin
							ev_single = pend_q;
							pend_d    = 1'b0;
							state_d   = sad_pkg::ST_IDLE;
						end
					end
				sad_pkg::ST_SECOND:
					if (any_above)
					begin
						cnt_d = cnt_inc;
						if (cnt_inc > 9'(limit_q))
						begin
							ev_single = pend_q;
							pend_d    = 1'b0;
							state_d   = sad_pkg::ST_SETTLE;
						end
					end
					else
					begin
						ev_double = 1'b1;
						ev_single = pend_q;
						pend_d    = 1'b0;
						state_d   = sad_pkg::ST_IDLE;
					end
				sad_pkg::ST_SETTLE:
					if (!any_above)
						state_d = sad_pkg::ST_IDLE;
				default:
				begin
					state_d = sad_pkg::ST_IDLE;
					pend_d  = 1'b0;
				end
			endcase
		end
	end

	// Flag update: a new event wins over the read clear
	always_comb
	begin
		flags_d = src_read ? 8'h00 : flags_q;
		flags_d[sad_pkg::BIT_SINGLE] = flags_d[sad_pkg::BIT_SINGLE] | ev_single;
		flags_d[sad_pkg::BIT_DOUBLE] = flags_d[sad_pkg::BIT_DOUBLE] | ev_double;
		flags_d[sad_pkg::BIT_ACT]    = flags_d[sad_pkg::BIT_ACT] | act_ev;
		flags_d[sad_pkg::BIT_INACT]  = flags_d[sad_pkg::BIT_INACT] | inact_ev;
	end

	// Chaining and sleep state
	assign look_inact_d = !link ? look_inact_q :
		(inact_ev ? 1'b0 : (act_ev ? 1'b1 : look_inact_q));
	assign asleep_d = (!auto_slp || !link) ? 1'b0 :
		(sleep_go ? 1'b1 : (wake ? 1'b0 : asleep_q));

	// Event and sequence registers
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_q      <= sad_pkg::ST_IDLE;
			cnt_q        <= 9'h000;
			pend_q       <= 1'b0;
			cand_q       <= 3'h0;
			shock_axis_q <= 3'h0;
			flags_q      <= 8'h00;
			asleep_q     <= 1'b0;
			look_inact_q <= 1'b1;
		end
		else
		begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			pend_q       <= pend_d;
			cand_q       <= cand_d;
			flags_q      <= flags_d;
			asleep_q     <= asleep_d;
			look_inact_q <= look_inact_d;
			if (ev_single || ev_double)
				shock_axis_q <= cand_q;
		end
	end

	// Registered outputs: read data, pins, rate
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			rdata_q     <= 8'h00;
			pin_a_q     <= 1'b0;
			pin_b_q     <= 1'b0;
			rate_code_q <= 4'h0;
		end
		else
		begin
			if (reg_rd)
				rdata_q <= rd_mux;
			pin_a_q     <= (|(flags_q & ~route_q)) ^ invert;
			pin_b_q     <= (|(flags_q & route_q)) ^ invert;
			rate_code_q <= asleep_q ? sad_pkg::SLEEP_RATE : rate_q[3:0];
		end
	end

	assign reg_rdata = rdata_q;
	assign irq_pin_a = pin_a_q;
	assign irq_pin_b = pin_b_q;
	assign asleep    = asleep_q;
	assign rate_code = rate_code_q;
	assign low_power = rate_q[sad_pkg::BIT_LOW_POWER];
	assign data_x    = sif.data[0];
	assign data_y    = sif.data[1];
	assign data_z    = sif.data[2];
	assign data_tick = sif.data_tick;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_read_clears_flags: assert property (
		(src_read && !ev_single && !ev_double && !act_ev && !inact_ev) |=> (flags_q == 8'h00))
		else $error("source read did not clear flags");
	a_set_beats_clear: assert property (
		(src_read && ev_single) |=> flags_q[sad_pkg::BIT_SINGLE])
		else $error("single event lost on clear");
	a_pin_route_b: assert property (
		((flags_q & route_q) != 8'h00 && !invert) |=> irq_pin_b)
		else $error("routed source did not reach pin b");
	a_pin_idle_inv: assert property (
		(flags_q == 8'h00 && invert) |=> (irq_pin_a && irq_pin_b))
		else $error("inverted idle pins not high");
	a_single_on_fall: assert property (
		(state_q == sad_pkg::ST_FIRST && sif.data_tick && !any_above && !dbl_ok && single_en)
		|=> flags_q[sad_pkg::BIT_SINGLE])
		else $error("single shock not flagged on fall");
	a_overlong_shock: assert property (
		(state_q == sad_pkg::ST_FIRST && sif.data_tick && any_above && cnt_inc > 9'(limit_q))
		|=> (state_q == sad_pkg::ST_SETTLE && !flags_q[sad_pkg::BIT_SINGLE]))
		else $error("overlong shock accepted");
	a_suppress_spike: assert property (
		(state_q == sad_pkg::ST_GAP && sif.data_tick && any_above && suppress)
		|=> (state_q == sad_pkg::ST_SETTLE))
		else $error("spike in latency did not cancel");
	a_double_needs_gap: assert property (
		(state_q == sad_pkg::ST_FIRST && (gap_q == 8'h00 || interval_q == 8'h00))
		|=> (state_q != sad_pkg::ST_GAP))
		else $error("double armed with zero timing");
	a_no_sleep_pending: assert property (
		(flags_q[sad_pkg::BIT_ACT] && !asleep_q && !src_read) |=> !asleep_q)
		else $error("slept with activity uncleared");
	a_wake_on_activity: assert property (
		(asleep_q && act_ev) |=> (!asleep_q && flags_q[sad_pkg::BIT_ACT] && look_inact_q) ##1
		(rate_code == $past(rate_q[3:0])))
		else $error("activity did not wake");
endmodule
`default_nettype wire

// ===== tb/sad_host_model.sv
// Host model driving the register port of the shock core
`timescale 1ns/1ps
`default_nettype none
module sad_host_model (
	// Clock
	input  wire logic       clk,
	// Register port
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// Idle port at time zero
	initial
	begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// One write pulse, then address and data scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask
	// One read pulse; data settles right after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
	// Service read of the source register clears the flags
	task automatic svc(output logic [7:0] d);
		rd(sad_pkg::ADDR_IRQ_SRC, d);
	endtask
endmodule
`default_nettype wire

// ===== tb/shock_activity_event_detector_bench.sv
// Self-checking bench of the shock and activity core
`timescale 1ns/1ps
`default_nettype none
module shock_activity_event_detector_bench;
	localparam logic [15:0] HI = 16'h0400;
	localparam logic [15:0] LO = 16'h0010;
	logic        clk, reset_n, reg_wr, reg_rd, sample_tick, data_tick;
	logic        activity_hit, inactivity_hit, irq_pin_a, irq_pin_b, asleep, low_power;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
	logic [15:0] raw_x, raw_y, raw_z, data_x, data_y, data_z, rx, ry, rz;
	logic [3:0]  rate_code;
	logic [31:0] o;
	int          fail_count, checks_done;
	integer      seed;
	sad_shock_core dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sample_tick, .raw_x, .raw_y, .raw_z, .activity_hit, .inactivity_hit, .data_x,
		.data_y, .data_z, .data_tick, .irq_pin_a, .irq_pin_b, .asleep, .rate_code, .low_power);
	sad_host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	// Clock of 50 ns
	always #25 clk = ~clk;
	// Compare and count
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Saturating offset correction
	function automatic logic [15:0] corr(input logic [15:0] r, input logic [7:0] f);
		int s;
		s = int'($signed(r)) + int'($signed(f)) * int'(sad_pkg::OFS_SCALE);
		if (s > 32767)
			s = 32767;
		if (s < -32768)
			s = -32768;
		return s[15:0];
	endfunction
	// One sample tick
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge clk);
		sample_tick <= 1'b1;
		raw_x       <= x;
		raw_y       <= y;
		raw_z       <= z;
		@(posedge clk);
		sample_tick <= 1'b0;
		#1;
	endtask
	task automatic ticks(input logic [15:0] x, input logic [15:0] y, input int n);
		repeat (n) smp(x, y, LO);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rv);
		chk(n, {8'h00, e}, {8'h00, rv});
	endtask
	task automatic cfg(input logic [7:0] ax, input logic [7:0] en, input logic [7:0] g);
		host.wr(sad_pkg::ADDR_AXIS, ax);
		host.wr(sad_pkg::ADDR_IRQ_EN, en);
		host.wr(sad_pkg::ADDR_GAP, g);
		host.wr(sad_pkg::ADDR_INTERVAL, 8'h0C);
	endtask
	// First shock, spike, gap, second shock, then resolve
	task automatic dbl(input logic [7:0] ax, input logic [7:0] g, input int s, input int m,
		input int h, input logic [1:0] e);
		// Clear flags left by earlier shocks
		host.svc(rv);
		cfg(ax, 8'h60, g);
		ticks(HI, LO, 1);
		ticks(LO, LO, 1);
		ticks(HI, LO, s);
		ticks(LO, LO, m);
		ticks(HI, LO, h);
		ticks(LO, LO, 24); // Gap and window run out
		host.svc(rv);
		chk("shock_pair", {14'h0, e}, {14'h0, rv[6:5]});
	endtask
	// Motion detector pulse
	task automatic hit(input logic a);
		@(posedge clk);
		activity_hit   <= a;
		inactivity_hit <= ~a;
		@(posedge clk);
		activity_hit   <= 1'b0;
		inactivity_hit <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Main sequence
	initial
	begin
		seed = 32'hA8C4;
		fail_count = 0;
		checks_done = 0;
		clk = 1'b0;
		reset_n = 1'b0;
		{sample_tick, activity_hit, inactivity_hit} = 3'b000;
		{raw_x, raw_y, raw_z} = 48'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 3; i++)
			rchk("ofs_reset", sad_pkg::ADDR_OFS_X + 8'(i), 8'h00);
		rchk("unmapped", 8'h40, 8'h00);
		for (int n = 0; n < 24; n++)
		begin
			o = $random(seed);
			rx = $random(seed);
			ry = $random(seed);
			rz = $random(seed);
			if (n < 4)
			begin
				o[7:0] = n[0] ? 8'h7F : 8'h80;
				rx = n[0] ? 16'h7FF0 : 16'h8010;
			end
			host.wr(sad_pkg::ADDR_OFS_X, o[7:0]);
			host.wr(sad_pkg::ADDR_OFS_Y, o[15:8]);
			host.wr(sad_pkg::ADDR_OFS_Z, o[23:16]);
			smp(rx, ry, rz);
			chk("data_tick", 16'h1, {15'h0, data_tick});
			chk("data_x", corr(rx, o[7:0]), data_x);
			chk("data_y", corr(ry, o[15:8]), data_y);
			chk("data_z", corr(rz, o[23:16]), data_z);
		end
		for (int i = 0; i < 3; i++)
			host.wr(sad_pkg::ADDR_OFS_X + 8'(i), 8'h00);
		host.wr(sad_pkg::ADDR_THRESH, 8'h10);
		host.wr(sad_pkg::ADDR_LIMIT, 8'h04);
		cfg(8'h04, 8'h40, 8'h02);
		ticks(HI, LO, 2);
		ticks(LO, LO, 4);
		chk("pin_a", 16'h1, {15'h0, irq_pin_a});
		rchk("src_single", sad_pkg::ADDR_IRQ_SRC, 8'h40);
		rchk("status_x", sad_pkg::ADDR_STATUS, 8'h04);
		rchk("src_clear", sad_pkg::ADDR_IRQ_SRC, 8'h00);
		host.wr(sad_pkg::ADDR_ROUTE, 8'h40);
		ticks(HI, LO, 4);
		ticks(LO, LO, 4);
		chk("pin_b", 16'h1, {15'h0, irq_pin_b});
		host.wr(sad_pkg::ADDR_FORMAT, 8'h20);
		repeat (2) @(posedge clk);
		// Pin a idle reads high, pin b active reads low
		#1 chk("pins_inv", 16'h2, {14'h0, irq_pin_a, irq_pin_b});
		host.wr(sad_pkg::ADDR_FORMAT, 8'h00);
		host.wr(sad_pkg::ADDR_ROUTE, 8'h00);
		rchk("src_b", sad_pkg::ADDR_IRQ_SRC, 8'h40);
		ticks(HI, LO, 5);
		ticks(LO, LO, 4);
		rchk("src_long", sad_pkg::ADDR_IRQ_SRC, 8'h00);
		ticks(LO, HI, 2);
		ticks(LO, LO, 4);
		rchk("src_axis", sad_pkg::ADDR_IRQ_SRC, 8'h00);
		host.wr(sad_pkg::ADDR_AXIS, 8'h06);
		ticks(LO, HI, 2);
		ticks(LO, LO, 4);
		rchk("status_y", sad_pkg::ADDR_STATUS, 8'h02);
		dbl(8'h04, 8'h02, 0, 3, 1, 2'b11);
		dbl(8'h0C, 8'h06, 1, 8, 1, 2'b10);
		dbl(8'h04, 8'h03, 0, 0, 4, 2'b10);
		dbl(8'h04, 8'h02, 0, 3, 6, 2'b10);
		dbl(8'h04, 8'h00, 0, 3, 1, 2'b10);
		host.wr(sad_pkg::ADDR_RATE, 8'h1A);
		host.wr(sad_pkg::ADDR_POWER, 8'h30);
		host.wr(sad_pkg::ADDR_IRQ_EN, 8'h18);
		hit(1'b1);
		host.svc(rv);
		chk("act_first", 16'h0, {14'h0, rv[4:3]});
		hit(1'b0);
		chk("asleep", 16'h1, {15'h0, asleep});
		chk("sleep_rate", 16'h7, {12'h0, rate_code});
		chk("low_power", 16'h1, {15'h0, low_power});
		host.rd(sad_pkg::ADDR_STATUS, rv);
		chk("status_sleep", 16'h1, {15'h0, rv[3]});
		host.svc(rv);
		chk("src_inact", 16'h1, {14'h0, rv[4:3]});
		hit(1'b1);
		chk("wake", 16'h0, {15'h0, asleep});
		chk("wake_rate", 16'hA, {12'h0, rate_code});
		hit(1'b0);
		chk("sleep_blocked", 16'h0, {15'h0, asleep});
		host.svc(rv);
		chk("src_act", 16'h3, {14'h0, rv[4:3]});
		stop_test();
	end
	// Watchdog on a hung run
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
